// [hw/sync_ram_pkg.sv]
// Shared constants and types for the multi-mode synchronous RAM.
package sync_ram_pkg;

    // Fixed geometry of the array.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int DEPTH  = 256;
    localparam int AGE_W  = 8;

    // Clock period and the maximum write cycle time, both in ns.
    localparam int CLK_PERIOD_NS        = 5;
    localparam int MAX_WRITE_CYCLE_NS   = 5;

    // Least spacing, in cycles, between two writes to one word.
    // Rising-edge core: ceil(t / T). Falling-edge core: ceil((t + T) / 2T).
    localparam int RISE_GAP_CYC = (MAX_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FALL_GAP_CYC = (MAX_WRITE_CYCLE_NS + 3 * CLK_PERIOD_NS - 1)
                                  / (2 * CLK_PERIOD_NS);

    // Port arrangement of the array.
    typedef enum logic [3:0] {
        MODE_SINGLE      = 4'h1,
        MODE_SIMPLE_DUAL = 4'h2,
        MODE_TRUE_DUAL   = 4'h4,
        MODE_TRI         = 4'h8
    } ram_mode_e;

    // Implementation style: write edge and read path.
    typedef enum logic [4:0] {
        IMPL_BLOCK_RISE = 5'h01,
        IMPL_BLOCK_FALL = 5'h02,
        IMPL_SMALL_FALL = 5'h04,
        IMPL_LOGIC_DFLT = 5'h08,
        IMPL_LOGIC_EMUL = 5'h10
    } ram_impl_e;

    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [AGE_W-1:0]  AGE_ONE  = 8'h01;

endpackage : sync_ram_pkg

// [hw/multi_mode_sync_ram.sv]
// Multi-mode synchronous RAM with write-contention tracking.
module multi_mode_sync_ram
    import sync_ram_pkg::*;
#(
    parameter ram_mode_e MODE = MODE_TRUE_DUAL,
    parameter ram_impl_e IMPL = IMPL_BLOCK_RISE
) (
    input  wire logic              ref_clk,   // 200 MHz clock, read and write.
    input  wire logic              rst_b,     // Synchronous reset, active low.
    input  wire logic [ADDR_W-1:0] addr_a,    // Port A address.
    input  wire logic [DATA_W-1:0] data_a,    // Port A write data.
    input  wire logic              wren_a,    // Port A write enable.
    input  wire logic [ADDR_W-1:0] rd_addr_a, // Tri-port first read address.
    output logic      [DATA_W-1:0] q_a,       // Port A read data.
    output logic                   q_a_bad,   // Port A word is unknown.
    input  wire logic [ADDR_W-1:0] addr_b,    // Port B address.
    input  wire logic [DATA_W-1:0] data_b,    // Port B write data.
    input  wire logic              wren_b,    // Port B write enable.
    output logic      [DATA_W-1:0] q_b,       // Port B read data.
    output logic                   q_b_bad,   // Port B word is unknown.
    output logic                   cfg_ok     // Requested mode is supported.
);

    // Only the large block styles can carry two write ports.
    localparam bit TDP_OK = (IMPL == IMPL_BLOCK_RISE) || (IMPL == IMPL_BLOCK_FALL);
    localparam ram_mode_e EFF_MODE =
        ((MODE == MODE_TRUE_DUAL) && !TDP_OK) ? MODE_SIMPLE_DUAL : MODE;
    localparam bit WR_FALL = (IMPL == IMPL_BLOCK_FALL) || (IMPL == IMPL_SMALL_FALL)
                             || (IMPL == IMPL_LOGIC_EMUL);
    localparam bit RD_CONT = (IMPL == IMPL_LOGIC_DFLT);
    localparam int GAP     = WR_FALL ? FALL_GAP_CYC : RISE_GAP_CYC;
    localparam logic [AGE_W-1:0] GAP_L = AGE_W'(GAP);

    localparam bit M_SP  = (EFF_MODE == MODE_SINGLE);
    localparam bit M_SDP = (EFF_MODE == MODE_SIMPLE_DUAL);
    localparam bit M_TDP = (EFF_MODE == MODE_TRUE_DUAL);
    localparam bit M_TRI = (EFF_MODE == MODE_TRI);

    // Storage and its per-word unknown marks.
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DEPTH-1:0]  bad_vec;

    // Input capture registers, one set per write port.
    logic [ADDR_W-1:0] wa_addr_reg, wb_addr_reg;
    logic [DATA_W-1:0] wa_data_reg, wb_data_reg;
    logic              wa_en_reg, wb_en_reg;

    // Last write seen on each port, and cycles elapsed since.
    logic [ADDR_W-1:0] a_hist_addr_reg, b_hist_addr_reg;
    logic [AGE_W-1:0]  a_age_reg, b_age_reg, a_age_next, b_age_next;
    logic              a_hist_vld_reg, b_hist_vld_reg;

    logic [DATA_W-1:0] q_a_reg, q_b_reg;
    logic              q_a_bad_reg, q_b_bad_reg;

    // A write clashes when the other port hits the same word this cycle,
    // or hit it fewer than GAP cycles ago.
    function automatic logic clash(input logic              fire,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic              o_fire,
                                   input logic [ADDR_W-1:0] o_addr,
                                   input logic              o_vld,
                                   input logic [ADDR_W-1:0] o_hist,
                                   input logic [AGE_W-1:0]  o_age);
        clash = fire && ((o_fire && (o_addr == addr))
                || (o_vld && (o_hist == addr) && (o_age < GAP_L)));
    endfunction : clash

    // Saturating age counter step.
    function automatic logic [AGE_W-1:0] age_step(input logic             fire,
                                                  input logic [AGE_W-1:0] age);
        age_step = fire ? AGE_ONE : ((age >= GAP_L) ? age : age + AGE_ONE);
    endfunction : age_step

    // Port roles per mode; the write port of simple dual and tri-port is A.
    wire               a_wr_port = 1'b1;
    wire               b_wr_port = M_TDP;
    wire [ADDR_W-1:0]  ra_addr   = M_TRI ? rd_addr_a : addr_a;
    wire               a_rd_port = M_SP || M_TDP || M_TRI;
    wire               b_rd_port = M_SDP || M_TDP || M_TRI;
    wire               rd_a_go   = a_rd_port && !((M_SP || M_TDP) && wren_a);
    wire               rd_b_go   = b_rd_port && !(M_TDP && wren_b);
    wire [DATA_W-1:0]  rd_a_word = mem[ra_addr];
    wire [DATA_W-1:0]  rd_b_word = mem[addr_b];
    wire               rd_a_bad  = bad_vec[ra_addr];
    wire               rd_b_bad  = bad_vec[addr_b];

    // Contention decode on the captured requests.
    wire a_clash = clash(wa_en_reg, wa_addr_reg, wb_en_reg, wb_addr_reg,
                         b_hist_vld_reg, b_hist_addr_reg, b_age_reg);
    wire b_clash = clash(wb_en_reg, wb_addr_reg, wa_en_reg, wa_addr_reg,
                         a_hist_vld_reg, a_hist_addr_reg, a_age_reg);
    wire same_word = wa_en_reg && wb_en_reg && (wa_addr_reg == wb_addr_reg);

    assign a_age_next = age_step(wa_en_reg, a_age_reg);
    assign b_age_next = age_step(wb_en_reg, b_age_reg);

    // Addresses, data and enables are latched on the rising edge whatever
    // edge later commits them, so the falling-edge core sees stable inputs.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wa_en_reg <= 1'b0;
            wb_en_reg <= 1'b0;
        end else begin
            wa_en_reg <= wren_a && a_wr_port;
            wb_en_reg <= wren_b && b_wr_port;
        end
        wa_addr_reg <= M_TRI || M_SDP ? addr_a : addr_a;
        wa_data_reg <= data_a;
        wb_addr_reg <= addr_b;
        wb_data_reg <= data_b;
    end

    // Write history used to judge spacing against the other port.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            a_hist_vld_reg  <= 1'b0;
            b_hist_vld_reg  <= 1'b0;
            a_age_reg       <= '0;
            b_age_reg       <= '0;
            a_hist_addr_reg <= '0;
            b_hist_addr_reg <= '0;
        end else begin
            a_hist_vld_reg  <= a_hist_vld_reg || wa_en_reg;
            b_hist_vld_reg  <= b_hist_vld_reg || wb_en_reg;
            a_age_reg       <= a_age_next;
            b_age_reg       <= b_age_next;
            a_hist_addr_reg <= wa_en_reg ? wa_addr_reg : a_hist_addr_reg;
            b_hist_addr_reg <= wb_en_reg ? wb_addr_reg : b_hist_addr_reg;
        end
    end

    // Core write on the configured edge. A clashing write still stores its data, except port B's write to the
    // word port A writes in the same cycle, which is dropped; the word is marked unknown; a spaced write clears the mark.
    generate
        if (WR_FALL) begin : g_wr_fall
            always_ff @(negedge ref_clk) begin
                if (!rst_b) begin
                    bad_vec <= '0;
                end else begin
                    if (wa_en_reg) begin
                        mem[wa_addr_reg]     <= wa_data_reg;
                        bad_vec[wa_addr_reg] <= a_clash;
                    end
                    if (wb_en_reg && !same_word) begin
                        mem[wb_addr_reg]     <= wb_data_reg;
                        bad_vec[wb_addr_reg] <= b_clash;
                    end
                end
            end
        end else begin : g_wr_rise
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    bad_vec <= '0;
                end else begin
                    if (wa_en_reg) begin
                        mem[wa_addr_reg]     <= wa_data_reg;
                        bad_vec[wa_addr_reg] <= a_clash;
                    end
                    if (wb_en_reg && !same_word) begin
                        mem[wb_addr_reg]     <= wb_data_reg;
                        bad_vec[wb_addr_reg] <= b_clash;
                    end
                end
            end
        end
    endgenerate

    // Registered read on the rising edge; in single and true dual-port the output holds while its port
    // writes, and a port with no read role holds its reset value.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q_a_reg     <= DATA_RST;
            q_b_reg     <= DATA_RST;
            q_a_bad_reg <= 1'b0;
            q_b_bad_reg <= 1'b0;
        end else begin
            q_a_reg     <= rd_a_go ? rd_a_word : q_a_reg;
            q_a_bad_reg <= rd_a_go ? rd_a_bad : q_a_bad_reg;
            q_b_reg     <= rd_b_go ? rd_b_word : q_b_reg;
            q_b_bad_reg <= rd_b_go ? rd_b_bad : q_b_bad_reg;
        end
    end

    // Default logic style follows the address with no clock; it is faster
    // but does not match the registered styles cycle for cycle.
    assign q_a     = RD_CONT ? (a_rd_port ? rd_a_word : DATA_RST) : q_a_reg;
    assign q_a_bad = RD_CONT ? (a_rd_port && rd_a_bad) : q_a_bad_reg;
    assign q_b     = RD_CONT ? (b_rd_port ? rd_b_word : DATA_RST) : q_b_reg;
    assign q_b_bad = RD_CONT ? (b_rd_port && rd_b_bad) : q_b_bad_reg;
    assign cfg_ok  = (EFF_MODE == MODE);

    // Helper state: the port A write committed one cycle ago.
    logic [ADDR_W-1:0] chk_addr_reg;
    logic [DATA_W-1:0] chk_data_reg;
    logic              chk_vld_reg, chk_clash_reg;
    wire  [DATA_W-1:0] chk_word = mem[chk_addr_reg];
    wire               chk_bad  = bad_vec[chk_addr_reg];
    wire               fall_busy = WR_FALL && (wa_en_reg || wb_en_reg);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            chk_vld_reg <= 1'b0;
        end else begin
            chk_vld_reg <= wa_en_reg;
        end
        chk_addr_reg  <= wa_addr_reg;
        chk_data_reg  <= wa_data_reg;
        chk_clash_reg <= a_clash;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_a_req;
        wren_a;
    endsequence

    sequence s_a_captured;
        wa_en_reg ##1 chk_vld_reg;
    endsequence

    a_sp_b_silent: assert property (M_SP |-> (q_b == DATA_RST) && !q_b_bad)
        else $error("single-port mode drove port B output");

    a_sdp_a_silent: assert property (M_SDP |-> (q_a == DATA_RST) && !q_a_bad)
        else $error("simple dual-port mode drove port A output");

    // Case equality: words never written read back unknown on both sides alike.
    a_read_a_reg: assert property (!RD_CONT && rd_a_go |=> q_a === $past(rd_a_word))
        else $error("port A registered read returned wrong word");

    a_read_b_reg: assert property (!RD_CONT && rd_b_go |=> q_b === $past(rd_b_word))
        else $error("port B registered read returned wrong word");

    a_read_b_hold: assert property (!RD_CONT && M_TDP && !rd_b_go |=> $stable(q_b))
        else $error("port B output moved during its write");

    a_cont_follow: assert property (RD_CONT && a_rd_port && chk_vld_reg && !chk_clash_reg
                                    && (ra_addr == chk_addr_reg) |-> q_a == chk_data_reg)
        else $error("continuous read did not follow committed write");

    a_capture_seq: assert property (s_a_req |-> ##1 ((wa_addr_reg == $past(addr_a))
                                    ##0 s_a_captured))
        else $error("port A request not captured on rising edge");

    a_commit_word: assert property (chk_vld_reg && !chk_clash_reg && !fall_busy
                                    |-> (chk_word == chk_data_reg) && !chk_bad)
        else $error("spaced write did not store data cleanly");

    a_clash_poison: assert property (chk_vld_reg && chk_clash_reg && !fall_busy
                                     |-> chk_bad)
        else $error("contended write did not mark word unknown");

    a_tdp_gate: assert property (!TDP_OK && wren_b |=> !wb_en_reg && (M_TDP == 1'b0))
        else $error("second write port active in unsupported style");

endmodule : multi_mode_sync_ram

// [sim/ram_user_model.sv]
// User-side model that drives the RAM ports just after a falling clock edge, once per call of put.
module ram_user_model
    import sync_ram_pkg::*;
(
    input  wire logic              ref_clk,   // Clock shared with the RAM.
    output logic      [ADDR_W-1:0] addr_a,    // Port A address.
    output logic      [DATA_W-1:0] data_a,    // Port A write data.
    output logic                   wren_a,    // Port A write enable.
    output logic      [ADDR_W-1:0] rd_addr_a, // Tri-port first read address.
    output logic      [ADDR_W-1:0] addr_b,    // Port B address.
    output logic      [DATA_W-1:0] data_b,    // Port B write data.
    output logic                   wren_b     // Port B write enable.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle, reading word zero on both ports, from time zero.
    initial begin
        {addr_a, data_a, wren_a, rd_addr_a, addr_b, data_b, wren_b} = '0;
    end

    // Present one cycle of traffic; it stands until the next call, so the RAM sees it
    // steady at the rising edge.
    task automatic put(input logic wa, input logic [ADDR_W-1:0] aa, input logic [DATA_W-1:0] da,
                       input logic wb, input logic [ADDR_W-1:0] ab, input logic [DATA_W-1:0] db,
                       input logic clash);
        @(negedge ref_clk);
        addr_a    = aa;
        data_a    = da;
        wren_a    = wa;
        rd_addr_a = aa;
        addr_b    = ab;
        data_b    = db;
        // A one-cycle gap meets the write cycle time; a same-cycle same-word pair is only
        // sent when a collision is wanted, otherwise port B holds off.
        wren_b    = wb && !(wa && aa == ab && !clash);
    endtask : put
endmodule : ram_user_model

// [sim/multi_mode_sync_ram_tb_top.sv]
// Self-checking bench for the multi-mode RAM in true dual-port, rising-write and falling-write forms, with a logic-cell build.
module multi_mode_sync_ram_tb_top
    import sync_ram_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic              port;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } row_s;

    logic              ref_clk = 1'b0;
    logic              rst_b   = 1'b0;
    logic [ADDR_W-1:0] addr_a, rd_addr_a, addr_b;
    logic [DATA_W-1:0] data_a, data_b, q_a, q_b, lq_b, fq_a, fq_b;
    logic              fq_a_bad, fq_b_bad;
    logic              wren_a, wren_b, q_a_bad, q_b_bad, cfg_ok, l_cfg_ok;
    int                mismatches = 0;
    int                compares   = 0;
    int                cycles     = 0;
    row_s              rows[6] = '{'{1'b0, 8'h00, 16'h1234}, '{1'b1, 8'hff, 16'hbeef},
                                   '{1'b0, 8'h7f, 16'hffff}, '{1'b1, 8'h80, 16'h0000},
                                   '{1'b0, 8'h55, 16'ha5a5}, '{1'b1, 8'h00, 16'h5a5a}};

    // Half-period toggle gives 200 MHz.
    always #2.5 ref_clk = ~ref_clk;

    ram_user_model um (.ref_clk(ref_clk), .addr_a(addr_a), .data_a(data_a), .wren_a(wren_a),
        .rd_addr_a(rd_addr_a), .addr_b(addr_b), .data_b(data_b), .wren_b(wren_b));

    multi_mode_sync_ram #(.MODE(MODE_TRUE_DUAL), .IMPL(IMPL_BLOCK_RISE)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .addr_a(addr_a), .data_a(data_a), .wren_a(wren_a),
        .rd_addr_a(rd_addr_a), .q_a(q_a), .q_a_bad(q_a_bad), .addr_b(addr_b),
        .data_b(data_b), .wren_b(wren_b), .q_b(q_b), .q_b_bad(q_b_bad), .cfg_ok(cfg_ok));

    // Falling-edge block build sees the same traffic and must read back the same words.
    multi_mode_sync_ram #(.MODE(MODE_TRUE_DUAL), .IMPL(IMPL_BLOCK_FALL)) u_fall (
        .ref_clk(ref_clk), .rst_b(rst_b), .addr_a(addr_a), .data_a(data_a), .wren_a(wren_a),
        .rd_addr_a(rd_addr_a), .q_a(fq_a), .q_a_bad(fq_a_bad), .addr_b(addr_b),
        .data_b(data_b), .wren_b(wren_b), .q_b(fq_b), .q_b_bad(fq_b_bad), .cfg_ok());

    // Logic-cell build asked for true dual; it must refuse and fall back to simple dual.
    multi_mode_sync_ram #(.MODE(MODE_TRUE_DUAL), .IMPL(IMPL_LOGIC_DFLT)) u_logic (
        .ref_clk(ref_clk), .rst_b(rst_b), .addr_a(addr_a), .data_a(data_a), .wren_a(wren_a),
        .rd_addr_a(rd_addr_a), .q_a(), .q_a_bad(), .addr_b(addr_b), .data_b(data_b),
        .wren_b(wren_b), .q_b(lq_b), .q_b_bad(), .cfg_ok(l_cfg_ok));

    task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask : chk

    // Two read cycles so a write two edges back is committed, then both ports are checked.
    // A word marked unknown has its data left unchecked.
    task automatic rb(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic bad);
        um.put(1'b0, a, 16'h0000, 1'b0, a, 16'h0000, 1'b0);
        um.put(1'b0, a, 16'h0000, 1'b0, a, 16'h0000, 1'b0);
        @(negedge ref_clk);
        chk("q_a_bad", {15'h0000, bad}, {15'h0000, q_a_bad});
        chk("q_b_bad", {15'h0000, bad}, {15'h0000, q_b_bad});
        chk("fq_a_bad", {15'h0000, bad}, {15'h0000, fq_a_bad});
        chk("fq_b_bad", {15'h0000, bad}, {15'h0000, fq_b_bad});
        if (!bad) begin
            chk("q_a", d, q_a);
            chk("q_b", d, q_b);
            chk("fq_a", d, fq_a);
            chk("fq_b", d, fq_b);
        end
    endtask : rb

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // Cuts a hang short; the whole sequence needs well under two hundred cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_sim();
        end
    end

    // Main sequence: table of single writes, then collisions, reset and refusals.
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            if (!rows[i].port) begin
                um.put(1'b1, rows[i].addr, rows[i].data, 1'b0, 8'h00, 16'h0000, 1'b0);
            end else begin
                um.put(1'b0, 8'h00, 16'h0000, 1'b1, rows[i].addr, rows[i].data, 1'b0);
            end
            rb(rows[i].addr, rows[i].data, 1'b0);
            if (!rows[i].port) begin
                chk("lq_b", rows[i].data, lq_b);
            end
        end
        // Both ports write different words in one cycle.
        um.put(1'b1, 8'h10, 16'haaaa, 1'b1, 8'h11, 16'h5555, 1'b0);
        rb(8'h10, 16'haaaa, 1'b0);
        rb(8'h11, 16'h5555, 1'b0);
        // Same word from A then B one cycle later is spaced enough: no unknown mark.
        um.put(1'b1, 8'h20, 16'h0101, 1'b0, 8'h00, 16'h0000, 1'b0);
        um.put(1'b0, 8'h00, 16'h0000, 1'b1, 8'h20, 16'h0202, 1'b0);
        rb(8'h20, 16'h0202, 1'b0);
        // Collision marks the word unknown.
        um.put(1'b1, 8'h02, 16'h0003, 1'b1, 8'h02, 16'h0004, 1'b1);
        rb(8'h02, 16'h0000, 1'b1);
        // Collision followed at once by a spaced write clears the mark.
        um.put(1'b1, 8'h01, 16'h0003, 1'b1, 8'h01, 16'h0004, 1'b1);
        um.put(1'b1, 8'h01, 16'h0004, 1'b0, 8'h00, 16'h0000, 1'b0);
        rb(8'h01, 16'h0004, 1'b1 == 1'b0);
        // Mid-run reset clears the outputs but keeps the array.
        rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("q_a", 16'h0000, q_a);
        chk("q_b", 16'h0000, q_b);
        rst_b = 1'b1;
        rb(8'hff, 16'hbeef, 1'b0);
        chk("cfg_ok", 16'h0001, {15'h0000, cfg_ok});
        chk("l_cfg_ok", 16'h0000, {15'h0000, l_cfg_ok});
        end_sim();
    end
endmodule : multi_mode_sync_ram_tb_top
